// *** logic/psi_black_det.v ***
/*
  One channel of the digital black detector.
  Assumes samples arrive from logic on ref_clk with a one-cycle strobe.
*/
`timescale 1ns/100ps
`include "psi_defs.vh"

module psi_black_det #(
  parameter SW    = 24,
  parameter COUNT = `PSI_BLACK_SAMPLES
) (
  input  wire          ref_clk,
  input  wire          rst,
  input  wire          smp_stb,
  input  wire [SW-1:0] smp,
  output reg           black_r
);

  reg  [13:0] zero_cnt_r;
  wire        is_zero = (smp == {SW{1'b0}});

  // ----------------------------------------------------------------
  // Run-length count of zero samples
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (rst) begin
      zero_cnt_r <= 14'h0000;
      black_r    <= 1'b0;
    end else if (smp_stb) begin
      if (!is_zero) begin
        // Cleared on the first non-zero sample, not after a hold-off
        zero_cnt_r <= 14'h0000; // R7
        black_r    <= 1'b0; // R7
      end else if (zero_cnt_r < COUNT[13:0]) begin
        zero_cnt_r <= zero_cnt_r + 14'h0001;
        if (zero_cnt_r == COUNT[13:0] - 14'h0001)
          black_r <= 1'b1; // R7
      end
    end
  end

endmodule

// *** logic/psi_defs.vh ***
/*
  Shared constants for the path status indicator logic: sync source codes,
  rate classes, the digital-black count, the blink period and the measuring
  window.
  Assumes a 10 MHz ref_clk. Included by every design file of the block.
*/
`ifndef PSI_DEFS_VH
`define PSI_DEFS_VH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define PSI_CLK_HZ          10000000
// Consecutive zero samples before a channel is called digital black
`define PSI_BLACK_SAMPLES   10000
// Blink half period, in ms, and in ref_clk cycles (4 Hz flashing)
`define PSI_BLINK_HALF_MS   125
`define PSI_BLINK_CYC       ((`PSI_CLK_HZ / 1000) * `PSI_BLINK_HALF_MS)
// Reference measuring window, in ms, and in ref_clk cycles
`define PSI_MEAS_MS         10
`define PSI_MEAS_CYC        ((`PSI_CLK_HZ / 1000) * `PSI_MEAS_MS)
// Tolerance window, in per mille of the nominal count
`define PSI_TOL_PERMILLE    10

// ----------------------------------------------------------------
// Sync source codes (one-hot indicator positions)
// ----------------------------------------------------------------
`define PSI_SRC_LOCAL       3'h0
`define PSI_SRC_WORD        3'h1
`define PSI_SRC_AES         3'h2
`define PSI_SRC_VIDEO       3'h3
`define PSI_SRC_SLOT_UP     3'h4
`define PSI_SRC_SLOT_LO     3'h5

// ----------------------------------------------------------------
// Rate codes: base in bits 1:0, multiplier in bits 3:2
// ----------------------------------------------------------------
`define PSI_BASE_NONE       2'h0
`define PSI_BASE_32K        2'h1
`define PSI_BASE_44K1       2'h2
`define PSI_BASE_48K        2'h3
`define PSI_MUL_X1          2'h0
`define PSI_MUL_X2          2'h1
`define PSI_MUL_X4          2'h2

`endif

// *** logic/psi_rate_meas.v ***
/*
  External reference rate meter: counts rising edges of the synchronised
  reference over a fixed window and classifies the result.
  Assumes ref_in is already synchronised to ref_clk.
*/
`timescale 1ns/100ps
`include "psi_defs.vh"

module psi_rate_meas #(
  parameter WIN_CYC  = `PSI_MEAS_CYC,
  parameter TOL_PM   = `PSI_TOL_PERMILLE
) (
  input  wire       ref_clk,
  input  wire       rst,
  input  wire       ref_in,
  output reg        present_r,
  output reg  [3:0] rate_r
);

  reg [16:0] win_cnt_r;
  reg [12:0] edge_cnt_r;
  reg        ref_d_r;
  reg [3:0]  cls;
  integer    i;

  // Nominal edge count of a rate, in Hz, over the window
  function [12:0] nom;
    input integer hz;
    integer       q;
    begin
      q   = hz / (`PSI_CLK_HZ / WIN_CYC);
      nom = q[12:0];
    end
  endfunction

  // Tolerance test against one nominal count
  function near;
    input [12:0] n;
    input [12:0] m;
    reg   [12:0] tol;
    begin
      tol  = (n * TOL_PM[12:0]) / 13'h03E8 + 13'h0001;
      near = (m + tol >= n) && (m <= n + tol);
    end
  endfunction

  // ----------------------------------------------------------------
  // Classification against the nine standard rates
  // ----------------------------------------------------------------
  always @* begin
    cls = 4'h0;
    for (i = 0; i < 3; i = i + 1) begin
      if (near(nom(32000 << i), edge_cnt_r))
        cls = {i[1:0], `PSI_BASE_32K}; // R19
      if (near(nom(44100 << i), edge_cnt_r))
        cls = {i[1:0], `PSI_BASE_44K1}; // R19
      if (near(nom(48000 << i), edge_cnt_r))
        cls = {i[1:0], `PSI_BASE_48K}; // R19
    end
  end

  // ----------------------------------------------------------------
  // Window counter; a rising edge is the sample instant
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (rst) begin
      win_cnt_r  <= 17'h0_0000;
      edge_cnt_r <= 13'h0000;
      ref_d_r    <= 1'b0;
      present_r  <= 1'b0;
      rate_r     <= 4'h0;
    end else begin
      ref_d_r <= ref_in;
      if (win_cnt_r == WIN_CYC[16:0] - 17'h0_0001) begin
        win_cnt_r  <= 17'h0_0000;
        edge_cnt_r <= 13'h0000;
        present_r  <= (cls[1:0] != `PSI_BASE_NONE); // R23
        rate_r     <= cls; // R19
      end else begin
        win_cnt_r <= win_cnt_r + 17'h0_0001;
        if (ref_in && !ref_d_r)
          edge_cnt_r <= edge_cnt_r + 13'h0001; // R16
      end
    end
  end

endmodule

// *** logic/psi_top.v ***
/*
  Path status indicator logic: turns one path's configuration and input
  samples into steady and flashing front-panel indicator states, and
  decides per channel whether dither is defeated.
  Assumes configuration inputs come from logic on ref_clk; the word clock,
  AES, video and slot reference presence lines come from pins.
*/
// Function
// R1: Patch lit on any cross-channel patching
// R2: Process when active; bypass when neither
// R3: Light every selected output wordlength range
// R4: Shaped noise lit if any channel shapes
// R5: Flat lit if any channel flat-dithers
// R6: Defeat dither when input length fits output
// R7: Black after 10000 zeros, clear instantly
// R8: Black input gets no dither
// R9: Auto lit when all active channels defeated
// R10: Mapping code lit, variant marks 20-bit
// R11: Range extension lit, variant marks 20-bit
// R12: One destination indicator per assigned port
// R13: Dual-wire indicator for high-rate outputs
// R14: Flash destinations that cannot be honoured
// R15: Six sync source indicators
// R16: Word clock rising edge is sample instant
// R17: Base rate plus x2 or x4 multiplier
// R18: Follow-external lit only when configured so
// R19: Measure and classify external reference rate
// R20: Explicit rate runs at ratio to reference
// R21: Missing reference falls back to local, flashes
// R22: Flash only unmet requests; steady shows actual
// R23: Configurable tolerance window for rate match
// R24: One common blink timer for flashing
`timescale 1ns/100ps
`include "psi_defs.vh"

module psi_top #(
  parameter NCH       = 8,
  parameter SW        = 24,
  parameter NWL       = 4,
  parameter NDST      = 4,
  parameter BLINK_CYC = `PSI_BLINK_CYC,
  parameter MEAS_CYC  = `PSI_MEAS_CYC,
  parameter TOL_PM    = `PSI_TOL_PERMILLE
) (
  input  wire              ref_clk,
  input  wire              rst,
  input  wire              cfg_patch,
  input  wire              cfg_process,
  input  wire [NCH-1:0]    ch_active,
  input  wire [NCH*NWL-1:0] ch_out_wl,
  input  wire [NCH*5-1:0]  ch_in_bits,
  input  wire [NCH*5-1:0]  ch_out_bits,
  input  wire [NCH-1:0]    ch_shape,
  input  wire [NCH-1:0]    ch_flat,
  input  wire              cfg_auto_defeat,
  input  wire              cfg_dig_to_dig,
  input  wire              smp_stb,
  input  wire [NCH*SW-1:0] smp,
  input  wire              enc_mapping,
  input  wire              enc_range_ext,
  input  wire              enc_20bit,
  input  wire [NDST-1:0]   dst_req,
  input  wire [NDST-1:0]   dst_conflict,
  input  wire [NDST-1:0]   dst_dual_wire,
  input  wire [2:0]        sync_sel,
  input  wire              word_clock_ref,
  input  wire              aes_ref_ok,
  input  wire              video_ref_ok,
  input  wire              digital_slot_upper_ref,
  input  wire              digital_slot_lower_ref,
  input  wire              cfg_follow_ext,
  input  wire [3:0]        cfg_rate,
  output reg               led_patch_r,
  output reg               led_process_r,
  output reg               led_bypass_r,
  output reg  [NWL-1:0]    led_wl_r,
  output reg               shaped_noise_indicator,
  output reg               led_flat_r,
  output reg               led_auto_r,
  output reg  [NCH-1:0]    dither_on_r,
  output reg               track_mapping_code,
  output reg               range_extension_code,
  output reg               twenty_bit_variant,
  output reg  [NDST-1:0]   led_dst_r,
  output reg  [NDST-1:0]   dual_wire_high_rate,
  output reg  [5:0]        led_sync_r,
  output reg  [2:0]        led_base_r,
  output reg               led_x2_r,
  output reg               led_x4_r,
  output reg               follow_external_rate,
  output reg               ratio_mode_r,
  output reg  [3:0]        run_rate_r
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg  [4:0] pin_s1_r;
  reg  [4:0] pin_s2_r;

  always @(posedge ref_clk) begin
    if (rst) begin
      pin_s1_r <= 5'h00;
      pin_s2_r <= 5'h00;
    end else begin
      pin_s1_r <= {digital_slot_lower_ref, digital_slot_upper_ref,
                   video_ref_ok, aes_ref_ok, word_clock_ref};
      pin_s2_r <= pin_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Common blink timer
  // ----------------------------------------------------------------
  reg [23:0] blink_cnt_r;
  reg        blink_r;

  always @(posedge ref_clk) begin
    if (rst) begin
      blink_cnt_r <= 24'h00_0000;
      blink_r     <= 1'b0;
    end else if (blink_cnt_r == BLINK_CYC[23:0] - 24'h00_0001) begin
      blink_cnt_r <= 24'h00_0000;
      blink_r     <= ~blink_r; // R24
    end else begin
      blink_cnt_r <= blink_cnt_r + 24'h00_0001;
    end
  end

  // ----------------------------------------------------------------
  // Per-channel digital black and dither defeat
  // ----------------------------------------------------------------
  wire [NCH-1:0] black;
  wire [NCH-1:0] defeat;

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      psi_black_det #(
        .SW    (SW),
        .COUNT (`PSI_BLACK_SAMPLES)
      ) u_black (
        .ref_clk (ref_clk),
        .rst     (rst),
        .smp_stb (smp_stb),
        .smp     (smp[g*SW +: SW]),
        .black_r (black[g])
      );
      // Black is zero-bit wordlength, so it is the same defeat condition
      assign defeat[g] = cfg_auto_defeat && cfg_dig_to_dig &&
                         ((ch_in_bits[g*5 +: 5] <= ch_out_bits[g*5 +: 5]) || // R6
                          black[g]); // R8
    end
  endgenerate

  // ----------------------------------------------------------------
  // Reference measurement
  // ----------------------------------------------------------------
  wire       meas_present;
  wire [3:0] meas_rate;

  psi_rate_meas #(
    .WIN_CYC (MEAS_CYC),
    .TOL_PM  (TOL_PM)
  ) u_meas (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .ref_in    (pin_s2_r[0]),
    .present_r (meas_present),
    .rate_r    (meas_rate)
  );

  // ----------------------------------------------------------------
  // Combined indicator states
  // ----------------------------------------------------------------
  reg  [NWL-1:0] wl_or;
  reg            ref_ok;
  reg  [5:0]     sync_nxt;
  reg  [3:0]     rate_nxt;
  integer        c;

  // Sync source code to one-hot indicator position
  function [5:0] src_onehot;
    input [2:0] s;
    begin
      src_onehot = 6'h01 << s;
    end
  endfunction

  always @* begin
    wl_or = {NWL{1'b0}};
    for (c = 0; c < NCH; c = c + 1)
      wl_or = wl_or | ch_out_wl[c*NWL +: NWL]; // R3
  end

  always @* begin
    case (sync_sel)
      `PSI_SRC_LOCAL:   ref_ok = 1'b1;
      `PSI_SRC_WORD:    ref_ok = meas_present;
      `PSI_SRC_AES:     ref_ok = pin_s2_r[1];
      `PSI_SRC_VIDEO:   ref_ok = pin_s2_r[2];
      `PSI_SRC_SLOT_UP: ref_ok = pin_s2_r[3];
      `PSI_SRC_SLOT_LO: ref_ok = pin_s2_r[4];
      default:          ref_ok = 1'b0;
    endcase
    if (ref_ok) begin
      sync_nxt = src_onehot(sync_sel); // R15
    end else begin
      // Local steady, requested source flashes
      sync_nxt = src_onehot(`PSI_SRC_LOCAL) | // R21
                 (blink_r ? src_onehot(sync_sel) : 6'h00); // R22
    end
    // Only the word clock input is measured; other references are taken
    // to run at the configured rate
    if (cfg_follow_ext && ref_ok && sync_sel == `PSI_SRC_WORD)
      rate_nxt = meas_rate; // R18
    else
      rate_nxt = cfg_rate;
  end

  // ----------------------------------------------------------------
  // Destination and rate indicator decode
  // ----------------------------------------------------------------
  reg  [NDST-1:0] dst_ok;
  reg  [NDST-1:0] dst_nxt;
  reg  [NDST-1:0] dual_nxt;
  reg  [2:0]      base_nxt;
  reg             x2_nxt;
  reg             x4_nxt;
  reg             ratio_nxt;

  always @* begin
    // An unmet assignment never lights steady, so it cannot be taken for a
    // working output
    dst_ok    = dst_req & ~dst_conflict;
    dst_nxt   = dst_ok | // R12
                (dst_req & dst_conflict & {NDST{blink_r}}); // R14
    dual_nxt  = dst_dual_wire & dst_ok; // R13
    base_nxt  = {rate_nxt[1:0] == `PSI_BASE_48K,
                 rate_nxt[1:0] == `PSI_BASE_44K1,
                 rate_nxt[1:0] == `PSI_BASE_32K}; // R17
    x2_nxt    = (rate_nxt[3:2] == `PSI_MUL_X2); // R17
    x4_nxt    = (rate_nxt[3:2] == `PSI_MUL_X4); // R17
    // Lock to the reference, run at explicit/reference ratio
    ratio_nxt = ref_ok && (sync_sel == `PSI_SRC_WORD) && !cfg_follow_ext &&
                (meas_rate != cfg_rate); // R20
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  // Every indicator leaves a flop, so the panel drivers never see a
  // glitch from the decode logic above
  always @(posedge ref_clk) begin
    if (rst) begin
      led_patch_r          <= 1'b0;
      led_process_r        <= 1'b0;
      led_bypass_r         <= 1'b0;
      led_wl_r             <= {NWL{1'b0}};
      shaped_noise_indicator <= 1'b0;
      led_flat_r           <= 1'b0;
      led_auto_r           <= 1'b0;
      dither_on_r          <= {NCH{1'b0}};
      track_mapping_code   <= 1'b0;
      range_extension_code <= 1'b0;
      twenty_bit_variant   <= 1'b0;
      led_dst_r            <= {NDST{1'b0}};
      dual_wire_high_rate  <= {NDST{1'b0}};
      led_sync_r           <= 6'h00;
      led_base_r           <= 3'h0;
      led_x2_r             <= 1'b0;
      led_x4_r             <= 1'b0;
      follow_external_rate <= 1'b0;
      ratio_mode_r         <= 1'b0;
      run_rate_r           <= 4'h0;
    end else begin
      led_patch_r   <= cfg_patch; // R1
      led_process_r <= cfg_process; // R2
      led_bypass_r  <= ~cfg_patch & ~cfg_process; // R2
      led_wl_r      <= wl_or;
      shaped_noise_indicator <= |(ch_shape & ch_active); // R4
      led_flat_r    <= |(ch_flat & ~ch_shape & ch_active); // R5
      // No active channel means nothing to report
      led_auto_r    <= (|ch_active) && ((defeat & ch_active) == ch_active); // R9
      dither_on_r   <= (ch_shape | ch_flat) & ch_active & ~defeat; // R6
      track_mapping_code   <= enc_mapping; // R10
      range_extension_code <= enc_range_ext; // R11
      twenty_bit_variant   <= enc_20bit & (enc_mapping | enc_range_ext); // R11
      led_dst_r     <= dst_nxt;
      dual_wire_high_rate <= dual_nxt;
      led_sync_r    <= sync_nxt;
      led_base_r    <= base_nxt;
      led_x2_r      <= x2_nxt;
      led_x4_r      <= x4_nxt;
      follow_external_rate <= cfg_follow_ext; // R18
      ratio_mode_r  <= ratio_nxt;
      run_rate_r    <= rate_nxt; // R20
    end
  end

endmodule

// *** test/psi_top_bench.sv ***
/*
  Self-checking bench for the path status indicator logic.
  Assumes the word clock model and the bound checker are compiled with it.
*/
`timescale 1ns/100ps

`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module psi_top_bench;
  typedef struct packed {
    logic pa, pr; logic [7:0] wl; logic [1:0] sh, fl; logic [2:0] en; logic [3:0] ds;
    logic [2:0] ppb; logic [3:0] wlx; logic [1:0] sf; logic [2:0] enx; logic [3:0] dsx;
  } psi_row_t;

  logic        ref_clk, rst, cfg_patch, cfg_process, cfg_auto_defeat, cfg_dig_to_dig;
  logic        smp_stb, enc_mapping, enc_range_ext, enc_20bit, word_clock_ref, aes_ref_ok;
  logic        video_ref_ok, digital_slot_upper_ref, digital_slot_lower_ref, cfg_follow_ext;
  logic        led_patch_r, led_process_r, led_bypass_r, shaped_noise_indicator, led_flat_r;
  logic        led_auto_r, track_mapping_code, range_extension_code, twenty_bit_variant;
  logic        led_x2_r, led_x4_r, follow_external_rate, ratio_mode_r, wclk_en;
  logic [1:0]  ch_active, ch_shape, ch_flat, dither_on_r;
  logic [3:0]  dst_req, dst_conflict, dst_dual_wire, cfg_rate, led_wl_r, led_dst_r;
  logic [3:0]  dual_wire_high_rate, run_rate_r;
  logic [7:0]  ch_out_wl;
  logic [9:0]  ch_in_bits, ch_out_bits;
  logic [15:0] smp;
  logic [2:0]  sync_sel, led_base_r;
  logic [5:0]  led_sync_r;
  int          checks = 0;
  int          n_mismatch = 0;
  int          cyc = 0;

  // Inputs beside expected {patch,process,bypass}, column, {shaped,flat}, codes, destinations
  psi_row_t rows [5] = '{
    '{1'h0, 1'h0, 8'h00, 2'h0, 2'h0, 3'h0, 4'h0, 3'h1, 4'h0, 2'h0, 3'h0, 4'h0},
    '{1'h1, 1'h0, 8'h21, 2'h1, 2'h2, 3'h4, 4'h5, 3'h4, 4'h3, 2'h3, 3'h4, 4'h5},
    '{1'h0, 1'h1, 8'h44, 2'h0, 2'h3, 3'h3, 4'hf, 3'h2, 4'h4, 2'h1, 3'h3, 4'hf},
    '{1'h1, 1'h1, 8'h88, 2'h3, 2'h3, 3'h5, 4'h8, 3'h6, 4'h8, 2'h2, 3'h5, 4'h8},
    '{1'h0, 1'h0, 8'h18, 2'h0, 2'h0, 3'h4, 4'h0, 3'h1, 4'h9, 2'h0, 3'h4, 4'h0}};

  psi_top #(.NCH(2), .SW(8), .NWL(4), .NDST(4), .BLINK_CYC(8), .MEAS_CYC(10000)) i_psi_top (.*);

  // 208-cycle period is 48.08 kHz, inside tolerance of the 48k class
  psi_wordclk_src #(.HALF(104)) i_psi_wordclk_src (.ref_clk(ref_clk), .en(wclk_en),
    .wave(word_clock_ref));

  always #50 ref_clk = ~ref_clk;

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      $display("[FAIL] run stalled");
      finish_test();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic strobe(input int n, input logic [15:0] v);
    @(posedge ref_clk);
    smp     <= v;
    smp_stb <= 1'b1;
    repeat (n) @(posedge ref_clk);
    smp_stb <= 1'b0;
  endtask

  // Flashing bit must be on half of 32 cycles, in phase with destination bit 1
  task automatic flash_chk(input bit sy, input int fb, input int sb);
    int n, bad;
    logic f, s;
    n = 0;
    bad = 0;
    repeat (32) begin
      @(posedge ref_clk);
      #1;
      f = sy ? led_sync_r[fb] : led_dst_r[fb];
      s = sy ? led_sync_r[sb] : led_dst_r[sb];
      if (f === 1'b1) n++;
      if (s !== 1'b1 || f !== led_dst_r[1]) bad++;
    end
    `CHK("flash count", 16, n);
    `CHK("flash phase", 0, bad);
  endtask

  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    wclk_en = 1'b0;
    {cfg_patch, cfg_process, cfg_auto_defeat, cfg_dig_to_dig, smp_stb, enc_mapping,
     enc_range_ext, enc_20bit, aes_ref_ok, video_ref_ok, digital_slot_upper_ref,
     digital_slot_lower_ref, cfg_follow_ext, ch_shape, ch_flat, dst_req, dst_conflict,
     dst_dual_wire, cfg_rate, ch_out_wl, ch_in_bits, ch_out_bits, smp, sync_sel} = '0;
    ch_active = 2'h3;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    wclk_en <= 1'b1;
    tick(0);
    `CHK("reset", 13'h0000, {led_bypass_r, led_sync_r, led_dst_r, dither_on_r});
    tick(1);
    `CHK("release edge", 1'b1, led_bypass_r);
    $display("reset test finished");
    foreach (rows[i]) begin
      @(posedge ref_clk);
      {cfg_patch, cfg_process, ch_out_wl, ch_shape, ch_flat} <= rows[i][36:23];
      {enc_mapping, enc_range_ext, enc_20bit, dst_req} <= rows[i][22:16];
      tick(1);
      `CHK("indicators", rows[i][15:0], {led_patch_r, led_process_r, led_bypass_r, led_wl_r,
        shaped_noise_indicator, led_flat_r, track_mapping_code, range_extension_code,
        twenty_bit_variant, led_dst_r});
    end
    $display("table test finished");
    @(posedge ref_clk);
    {dst_req, dst_conflict, dst_dual_wire} <= {4'hf, 4'ha, 4'h4};
    tick(1);
    `CHK("dual wire", 4'h4, dual_wire_high_rate);
    flash_chk(0, 3, 0);
    $display("destination test finished");
    for (int b = 1; b < 4; b++) begin
      for (int m = 0; m < 3; m++) begin
        @(posedge ref_clk);
        cfg_rate <= {m[1:0], b[1:0]};
        tick(1);
        `CHK("rate", {3'h1 << (b - 1), m == 1, m == 2, 1'b0}, {led_base_r, led_x2_r, led_x4_r, follow_external_rate});
      end
    end
    @(posedge ref_clk);
    cfg_follow_ext <= 1'b1;
    tick(1);
    `CHK("follow", 1'b1, follow_external_rate);
    $display("rate test finished");
    @(posedge ref_clk);
    {ch_flat, ch_shape, cfg_dig_to_dig, cfg_follow_ext} <= {2'h3, 2'h0, 1'b1, 1'b0};
    {ch_in_bits, ch_out_bits} <= {5'h10, 5'h18, 5'h10, 5'h10};
    tick(1);
    `CHK("defeat off", 2'h3, dither_on_r);
    @(posedge ref_clk);
    cfg_auto_defeat <= 1'b1;
    tick(1);
    `CHK("length defeat", 3'h2, {dither_on_r, led_auto_r});
    @(posedge ref_clk);
    ch_active <= 2'h2;
    tick(1);
    `CHK("active mask", 3'h1, {dither_on_r, led_auto_r});
    @(posedge ref_clk);
    ch_active <= 2'h3;
    strobe(9999, 16'h0100);
    tick(2);
    `CHK("short zero run", 2'h1, dither_on_r);
    strobe(1, 16'h0100);
    tick(1);
    `CHK("black", 3'h1, {dither_on_r, led_auto_r});
    strobe(1, 16'h0105);
    tick(1);
    `CHK("black cleared", 3'h2, {dither_on_r, led_auto_r});
    $display("dither test finished");
    @(posedge ref_clk);
    {aes_ref_ok, video_ref_ok, digital_slot_upper_ref, digital_slot_lower_ref} <= 4'hf;
    tick(12000);
    for (int k = 0; k < 6; k++) begin
      @(posedge ref_clk);
      sync_sel <= k[2:0];
      tick(4);
      `CHK("sync source", 6'h01 << k, led_sync_r);
      if (k == 1) begin
        `CHK("ratio", 5'h1b, {ratio_mode_r, run_rate_r});
        @(posedge ref_clk);
        cfg_follow_ext <= 1'b1;
        tick(1);
        `CHK("follow rate", 6'h13, {ratio_mode_r, follow_external_rate, run_rate_r});
        `CHK("follow leds", 5'h10, {led_base_r, led_x2_r, led_x4_r});
        @(posedge ref_clk);
        cfg_follow_ext <= 1'b0;
      end
    end
    @(posedge ref_clk);
    {sync_sel, aes_ref_ok} <= {3'h2, 1'b0};
    tick(4);
    flash_chk(1, 2, 0);
    @(posedge ref_clk);
    {sync_sel, wclk_en} <= {3'h1, 1'b0};
    tick(25000);
    flash_chk(1, 1, 0);
    $display("sync test finished");
    finish_test();
  end
endmodule

// *** test/psi_top_sva.sv ***
/*
  Checker for the path status indicator logic.
  Assumes it is bound into psi_top and sees only that module's ports.
*/
`timescale 1ns/100ps

module psi_top_sva #(
  parameter NCH  = 8,
  parameter SW   = 24,
  parameter NWL  = 4,
  parameter NDST = 4
) (
  input logic                 ref_clk,
  input logic                 rst,
  input logic                 cfg_patch,
  input logic                 cfg_process,
  input logic [NCH-1:0]       ch_active,
  input logic [NCH*NWL-1:0]   ch_out_wl,
  input logic                 cfg_auto_defeat,
  input logic                 cfg_dig_to_dig,
  input logic                 smp_stb,
  input logic [NCH*SW-1:0]    smp,
  input logic                 enc_mapping,
  input logic                 enc_range_ext,
  input logic                 enc_20bit,
  input logic [NDST-1:0]      dst_req,
  input logic [NDST-1:0]      dst_conflict,
  input logic [2:0]           sync_sel,
  input logic                 cfg_follow_ext,
  input logic [3:0]           cfg_rate,
  input logic                 led_patch_r,
  input logic                 led_bypass_r,
  input logic [NWL-1:0]       led_wl_r,
  input logic [NCH-1:0]       dither_on_r,
  input logic                 twenty_bit_variant,
  input logic [NDST-1:0]      led_dst_r,
  input logic [5:0]           led_sync_r,
  input logic [2:0]           led_base_r,
  input logic                 led_x2_r,
  input logic                 led_x4_r
);
  localparam int BLACK = 10000;
  logic [NWL-1:0] wl_or;
  logic [13:0]    zc_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  always_comb begin
    wl_or = '0;
    for (int c = 0; c < NCH; c++) wl_or = wl_or | ch_out_wl[c*NWL +: NWL];
  end

  // Zero run on channel 0; saturates so a long silence never wraps
  always_ff @(posedge ref_clk) begin
    if (rst || (smp_stb && smp[SW-1:0] != '0)) begin
      zc_r <= 14'h0000;
    end else if (smp_stb && zc_r < BLACK) begin
      zc_r <= zc_r + 14'h0001;
    end
  end

  a_patch_led: assert property (
    !$past(rst) |-> led_patch_r == $past(cfg_patch))
    else $error("patch indicator does not follow patching");
  a_bypass_led: assert property (
    !$past(rst) |-> led_bypass_r == $past(!cfg_patch && !cfg_process))
    else $error("bypass indicator wrong");
  a_wl_column: assert property (
    !$past(rst) && $past(&ch_active) |-> led_wl_r == $past(wl_or))
    else $error("wordlength column is not the union of channels");
  a_enc_variant: assert property (
    !$past(rst) && $past(enc_mapping || enc_range_ext) |-> twenty_bit_variant == $past(enc_20bit))
    else $error("variant indicator wrong");
  a_dst_steady: assert property (
    !$past(rst) |-> ((led_dst_r ^ $past(dst_req)) & ~$past(dst_conflict)) == '0)
    else $error("honoured destination not steady");
  a_black_mute: assert property (
    zc_r >= BLACK && cfg_auto_defeat && cfg_dig_to_dig |=> !dither_on_r[0])
    else $error("dither on a black channel");
  a_sync_local: assert property (
    !$past(rst) && $past(sync_sel) == 3'h0 |-> led_sync_r == 6'h01)
    else $error("local sync not shown alone");
  a_rate_leds: assert property (
    !$past(rst) && !$past(cfg_follow_ext) && $past(cfg_rate[1:0]) != 2'h0 |->
      led_base_r == 3'h1 << ($past(cfg_rate[1:0]) - 2'h1) &&
      led_x2_r == ($past(cfg_rate[3:2]) == 2'h1) && led_x4_r == ($past(cfg_rate[3:2]) == 2'h2))
    else $error("rate indicators wrong");
endmodule

bind psi_top psi_top_sva #(.NCH(NCH), .SW(SW), .NWL(NWL), .NDST(NDST)) i_psi_top_sva (.*);

// *** test/psi_wordclk_src.sv ***
/*
  Word clock source model: a square reference wave at a fixed period.
  Assumes one ref_clk domain; the design synchronises the wave itself.
*/
`timescale 1ns/100ps

module psi_wordclk_src #(
  parameter int HALF = 100
) (
  input  wire logic ref_clk,
  input  wire logic en,
  output logic      wave
);
  int cnt = 0;

  initial wave = 1'b0;

  // Unplugged input rests low through its termination, so no edges arrive
  always @(posedge ref_clk) begin
    if (!en) begin
      cnt  <= 0;
      wave <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt  <= 0;
      wave <= ~wave;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
